/* include/rfm_params.svh */
// register offsets, frame constants and command codes of the frame formatter
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH
`define RFM_ADDR_CMD_DATA 8'h48
`define RFM_ADDR_CMD_CTRL 8'h4a
`define RFM_CMD_TYPE0 8'h00
`define RFM_CMD_TYPE1 8'h01
`define RFM_HDR_FIXED 8'h05
`define RFM_HDR_LEN_POS 3'h2
`define RFM_HDR_SEQ_POS 3'h1
`define RFM_MAX_FRAME 14'h20f8
`define RFM_BLOCK_LEN 8'h40
`define RFM_CRC8_POLY 8'h07
`define RFM_CRC16_POLY 16'h1021
`define RFM_SYNC_WORD 16'h59f3
`define RFM_PREAMBLE 8'h77
`define RFM_PREAMBLE_LEN 4'h4
`define RFM_RXC_CRCERR 3'h1
`define RFM_RXC_HEADER 8'h80
`endif

/* include/rfm_pkg.sv */
// types shared by the frame formatter files
package rfm_pkg;
  typedef enum logic [0:0] {
    RFM_TYPE0 = 1'b0,
    RFM_TYPE1 = 1'b1
  } rfm_ftype_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } rfm_hostwr_t;

  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [7:0] data;
  } rfm_rxbyte_t;
endpackage

/* rtl/rfm_crc.sv */
// serial-in byte CRC engine, width and polynomial set by parameters
`timescale 1ns/1ns
`include "rfm_params.svh"
module rfm_crc import rfm_pkg::*; #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] POLY = `RFM_CRC16_POLY
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] dataIn,
  // result
  output logic [WIDTH-1:0] crc
);
  logic [WIDTH-1:0] next_crc;

  always_comb begin
    next_crc = crc;
    for (int i = 7; i >= 0; i--) begin
      if (next_crc[WIDTH-1] ^ dataIn[i]) begin
        next_crc = {next_crc[WIDTH-2:0], 1'b0} ^ POLY;
      end else begin
        next_crc = {next_crc[WIDTH-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= '0;
    end else if (clear) begin
      crc <= '0;
    end else if (step) begin
      crc <= next_crc;
    end
  end
endmodule

/* rtl/rfm_hamming.sv */
// hamming(8,4) nibble encoder used for the coded frame type
`timescale 1ns/1ns
module rfm_hamming (
  // nibble in
  input wire logic [3:0] nibble,
  // codeword out
  output logic [7:0] code
);
  logic p1;
  logic p2;
  logic p3;
  logic p4;

  always_comb begin
    p1 = nibble[0] ^ nibble[1] ^ nibble[3];
    p2 = nibble[0] ^ nibble[2] ^ nibble[3];
    p3 = nibble[1] ^ nibble[2] ^ nibble[3];
    p4 = ^{nibble, p1, p2, p3};
    code = {p4, p3, p2, p1, nibble};
  end
endmodule

/* rtl/rtcm_frame_formatter.sv */
// frame formatter: transmit framer from command register writes, receive record writer
// Summary of operation
// - frame types 0 plain and 1 coded
// - device inserts preamble, sync, type, crcs, coding
// - device adds one for header crc
// - device overwrites header byte two with sequence
// - payload split in blocks with crc16, parity
// - receiver finds type and length, reports type
// - receive record starts control byte, five header
// - per block control byte shows crc failure
// - block byte gives blocks remaining and index
// - two bytes give block data count
// - block data follows; repeat for all blocks
// - fixed blocks of BLOCK_LEN bytes, only the last may be shorter
// - frames up to 8440 bytes handled
`timescale 1ns/1ns
`include "rfm_params.svh"
module rtcm_frame_formatter import rfm_pkg::*; #(
  parameter logic [7:0] BLOCK_LEN = `RFM_BLOCK_LEN,
  parameter logic [13:0] MAX_FRAME = `RFM_MAX_FRAME
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host register writes
  input rfm_hostwr_t hostWr,
  // transmit byte stream to the modulator
  output logic txValid,
  output logic [7:0] txByte,
  output logic txLast,
  input wire logic txReady,
  // demodulated bytes after frame sync
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxSyncFound,
  // receive fifo writes
  output rfm_rxbyte_t rxOut,
  // status
  output rfm_ftype_t rxType,
  output logic txBusy
);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE = 3'b001,
    TX_SYNC = 3'b010,
    TX_HDR = 3'b011,
    TX_HCRC = 3'b100,
    TX_DATA = 3'b101,
    TX_BCRC = 3'b110
  } rfm_txst_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_HDR = 3'b001,
    RX_BHDR = 3'b010,
    RX_DATA = 3'b011,
    RX_CRC = 3'b100,
    RX_EMIT = 3'b101
  } rfm_rxst_t;

  // transmit side: one byte held, host writes while busy must wait for txReady
  rfm_txst_t txState;
  rfm_ftype_t txType;
  logic [7:0] seqNum;
  logic [13:0] frameLen;
  logic [13:0] byteCount;
  logic [7:0] hdrLen;
  logic [7:0] blkCount;
  logic [1:0] sub;
  logic [7:0] heldByte;
  logic heldValid;
  logic [7:0] hCrc;
  logic [15:0] bCrc;
  logic [7:0] hamCode;
  logic dataWr;
  logic ctrlWr;
  logic [7:0] plainByte;
  logic [13:0] reqLen;
  localparam logic [15:0] SYNC_WORD = `RFM_SYNC_WORD;

  assign dataWr = hostWr.write && hostWr.addr == `RFM_ADDR_CMD_DATA;
  assign ctrlWr = hostWr.write && hostWr.addr == `RFM_ADDR_CMD_CTRL;
  assign txBusy = txState != TX_IDLE;
  assign reqLen = {6'h00, hostWr.data} << 6;
  // full count compare, so optional header bytes pass through untouched
  assign plainByte = (txState == TX_HDR && byteCount == 14'(`RFM_HDR_SEQ_POS)) ? seqNum :
                     (txState == TX_HDR && byteCount == 14'(`RFM_HDR_LEN_POS)) ?
                     heldByte + 8'h01 : heldByte;

  // frame type latch, taken from bit 0 of the control byte while not busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txType <= RFM_TYPE0;
    end else if (ctrlWr && !txBusy) begin
      txType <= rfm_ftype_t'(hostWr.data[0]);
    end
  end

  // input byte holding stage; the host is paced by txBusy and the stream
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      heldByte <= 8'h00;
      heldValid <= 1'b0;
    end else if (dataWr) begin
      heldByte <= hostWr.data;
      heldValid <= 1'b1;
    end else if (txValid && txReady && (txState == TX_HDR || txState == TX_DATA) &&
                 (sub == 2'h2 || txType == RFM_TYPE0)) begin
      heldValid <= 1'b0;
    end
  end

  rfm_crc #(.WIDTH(8), .POLY(`RFM_CRC8_POLY)) uHdrCrc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(txState == TX_SYNC),
    .step(txState == TX_HDR && txValid && txReady && sub == 2'h0),
    .dataIn(txByte),
    .crc(hCrc)
  );

  rfm_crc #(.WIDTH(16), .POLY(`RFM_CRC16_POLY)) uBlkCrc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(txState == TX_HCRC || (txState == TX_BCRC && sub[0] && txReady)),
    .step(txState == TX_DATA && txValid && txReady && sub == 2'h0),
    .dataIn(heldByte),
    .crc(bCrc)
  );

  rfm_hamming uHam (
    .nibble(sub == 2'h1 ? plainByte[3:0] : plainByte[7:4]),
    .code(hamCode)
  );

  // transmit byte selection: header byte 2 and 3 substituted on the fly
  always_comb begin
    txValid = 1'b0;
    txByte = 8'h00;
    unique case (txState)
      TX_IDLE: begin
        txValid = 1'b0;
      end
      TX_PRE: begin
        txValid = 1'b1;
        txByte = `RFM_PREAMBLE;
      end
      TX_SYNC: begin
        txValid = 1'b1;
        txByte = sub[0] ? SYNC_WORD[7:0] : SYNC_WORD[15:8];
        if (sub == 2'h2) begin
          txByte = {7'h00, txType};
        end
      end
      TX_HDR, TX_DATA: begin
        txValid = heldValid;
        txByte = plainByte;
        if (txType == RFM_TYPE1 && sub != 2'h0) begin
          txByte = hamCode;
        end
      end
      TX_HCRC: begin
        txValid = 1'b1;
        txByte = hCrc;
      end
      TX_BCRC: begin
        txValid = 1'b1;
        txByte = sub[0] ? bCrc[7:0] : bCrc[15:8];
      end
      default: begin
        txValid = 1'b0;
      end
    endcase
  end

  assign txLast = txState == TX_BCRC && sub[0] && byteCount >= frameLen;

  // coded frames send each byte as two hamming words after the plain byte slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      sub <= 2'h0;
      byteCount <= 14'h0000;
      blkCount <= 8'h00;
      hdrLen <= 8'h00;
      seqNum <= 8'h00;
      frameLen <= 14'h0000;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          if (ctrlWr) begin
            frameLen <= reqLen > MAX_FRAME ? MAX_FRAME : reqLen;
            txState <= TX_PRE;
            sub <= 2'h0;
          end
        end
        TX_PRE: begin
          if (txReady) begin
            sub <= sub + 2'h1;
            if (sub == 2'(`RFM_PREAMBLE_LEN - 4'h1)) begin
              sub <= 2'h0;
              txState <= TX_SYNC;
            end
          end
        end
        TX_SYNC: begin
          if (txReady) begin
            sub <= sub + 2'h1;
            if (sub == 2'h2) begin
              sub <= 2'h0;
              byteCount <= 14'h0000;
              hdrLen <= `RFM_HDR_FIXED;
              txState <= TX_HDR;
            end
          end
        end
        TX_HDR: begin
          if (txValid && txReady) begin
            if (txType == RFM_TYPE1 && sub != 2'h2) begin
              sub <= sub + 2'h1;
            end else begin
              sub <= 2'h0;
              byteCount <= byteCount + 14'h0001;
              if (byteCount == 14'(`RFM_HDR_LEN_POS)) begin
                hdrLen <= heldByte;
              end
              if (byteCount + 14'h0001 == {6'h00, hdrLen} && byteCount >= 14'h0004) begin
                txState <= TX_HCRC;
              end
            end
          end
        end
        TX_HCRC: begin
          if (txReady) begin
            seqNum <= seqNum + 8'h01;
            byteCount <= 14'h0000;
            blkCount <= 8'h00;
            txState <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txValid && txReady) begin
            if (txType == RFM_TYPE1 && sub != 2'h2) begin
              sub <= sub + 2'h1;
            end else begin
              sub <= 2'h0;
              byteCount <= byteCount + 14'h0001;
              blkCount <= blkCount + 8'h01;
              if (blkCount + 8'h01 == BLOCK_LEN || byteCount + 14'h0001 >= frameLen) begin
                txState <= TX_BCRC;
              end
            end
          end
        end
        TX_BCRC: begin
          if (txReady) begin
            sub <= sub + 2'h1;
            if (sub[0]) begin
              sub <= 2'h0;
              blkCount <= 8'h00;
              txState <= byteCount >= frameLen ? TX_IDLE : TX_DATA;
            end
          end
        end
        default: begin
          txState <= TX_IDLE;
        end
      endcase
    end
  end

  // receive side: header, then one record per block of up to BLOCK_LEN bytes
  rfm_rxst_t rxState;
  logic [2:0] rxHdrIdx;
  logic [13:0] rxRemain;
  logic [7:0] rxBlkIdx;
  logic [7:0] rxBlkTotal;
  logic [7:0] rxBlkLen;
  logic [7:0] rxBlkPos;
  logic [7:0] rxMem [0:255];
  logic [1:0] rxCrcIdx;
  logic [15:0] rxCrcGot;
  logic [15:0] rxCrcCalc;
  logic [2:0] rxEmitStep;

  rfm_crc #(.WIDTH(16), .POLY(`RFM_CRC16_POLY)) uRxCrc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(rxState == RX_BHDR),
    .step(rxState == RX_DATA && rxValid),
    .dataIn(rxByte),
    .crc(rxCrcCalc)
  );

  always_ff @(posedge ref_clk) begin
    if (rxState == RX_DATA && rxValid) begin
      rxMem[rxBlkPos] <= rxByte;
    end
  end

  // records are held a block at a time so the crc verdict precedes the data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxOut <= '0;
      rxType <= RFM_TYPE0;
      rxHdrIdx <= 3'h0;
      rxRemain <= 14'h0000;
      rxBlkIdx <= 8'h00;
      rxBlkTotal <= 8'h00;
      rxBlkLen <= 8'h00;
      rxBlkPos <= 8'h00;
      rxCrcIdx <= 2'h0;
      rxCrcGot <= 16'h0000;
      rxEmitStep <= 3'h0;
    end else begin
      rxOut <= '0;
      unique case (rxState)
        RX_IDLE: begin
          if (rxSyncFound && rxValid) begin
            rxType <= rfm_ftype_t'(rxByte[0]);
            rxOut <= '{valid: 1'b1, ctrl: 1'b1, data: `RFM_RXC_HEADER | {7'h00, rxByte[0]}};
            rxHdrIdx <= 3'h0;
            rxState <= RX_HDR;
          end
        end
        RX_HDR: begin
          if (rxValid) begin
            rxOut <= '{valid: 1'b1, ctrl: 1'b0, data: rxByte};
            rxHdrIdx <= rxHdrIdx + 3'h1;
            if (rxHdrIdx == `RFM_HDR_LEN_POS + 3'h1) begin
              rxRemain <= {rxByte, 6'h00};
              rxBlkTotal <= rxByte;
            end
            if (rxHdrIdx == 3'(`RFM_HDR_FIXED - 8'h01)) begin
              rxBlkIdx <= 8'h00;
              rxState <= RX_BHDR;
            end
          end
        end
        RX_BHDR: begin
          rxBlkPos <= 8'h00;
          rxBlkLen <= rxRemain > {6'h00, BLOCK_LEN} ? BLOCK_LEN : rxRemain[7:0];
          rxCrcIdx <= 2'h0;
          rxState <= rxRemain == 14'h0000 ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rxValid) begin
            rxBlkPos <= rxBlkPos + 8'h01;
            if (rxBlkPos + 8'h01 == rxBlkLen) begin
              rxState <= RX_CRC;
            end
          end
        end
        RX_CRC: begin
          if (rxValid) begin
            rxCrcGot <= {rxCrcGot[7:0], rxByte};
            rxCrcIdx <= rxCrcIdx + 2'h1;
            if (rxCrcIdx == 2'h1) begin
              rxEmitStep <= 3'h0;
              rxBlkPos <= 8'h00;
              rxState <= RX_EMIT;
            end
          end
        end
        RX_EMIT: begin
          rxEmitStep <= rxEmitStep == 3'h4 ? 3'h4 : rxEmitStep + 3'h1;
          unique case (rxEmitStep)
            3'h0: rxOut <= '{valid: 1'b1, ctrl: 1'b1,
                             data: {7'h00, rxType} |
                                   ({7'h00, rxCrcGot != rxCrcCalc} << `RFM_RXC_CRCERR)};
            3'h1: rxOut <= '{valid: 1'b1, ctrl: 1'b0,
                             data: {rxBlkTotal[3:0] - rxBlkIdx[3:0] - 4'h1,
                                    rxBlkIdx[3:0]}};
            3'h2: rxOut <= '{valid: 1'b1, ctrl: 1'b0, data: 8'h00};
            3'h3: rxOut <= '{valid: 1'b1, ctrl: 1'b0, data: rxBlkLen};
            default: begin
              rxOut <= '{valid: 1'b1, ctrl: 1'b0, data: rxMem[rxBlkPos]};
              rxBlkPos <= rxBlkPos + 8'h01;
              if (rxBlkPos + 8'h01 == rxBlkLen) begin
                rxRemain <= rxRemain - {6'h00, rxBlkLen};
                rxBlkIdx <= rxBlkIdx + 8'h01;
                rxState <= RX_BHDR;
              end
            end
          endcase
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end
endmodule

/* test/rfm_frame_chk.sv */
// port checker for the frame formatter
`timescale 1ns/1ns
`include "rfm_params.svh"
module rfm_frame_chk import rfm_pkg::*; #(
  parameter logic [7:0] BLOCK_LEN = `RFM_BLOCK_LEN,
  parameter logic [13:0] MAX_FRAME = `RFM_MAX_FRAME
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host and transmit
  input rfm_hostwr_t hostWr,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic txBusy,
  // receive
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxSyncFound,
  input rfm_rxbyte_t rxOut,
  input rfm_ftype_t rxType
);
  localparam logic [15:0] SYNC = `RFM_SYNC_WORD;
  logic [13:0] txPos;
  logic [1:0] wrCnt;
  logic [7:0] hdrLen;
  logic coded;
  wire logic ctrlWr = hostWr.write && hostWr.addr == `RFM_ADDR_CMD_CTRL && !txBusy;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) txPos <= 14'h0;
    else if (!txBusy) txPos <= 14'h0;
    else if (txValid && txReady) txPos <= txPos + 14'h1;
  end
  // header length is the third data byte; the count saturates so later bytes leave it alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrCnt <= 2'h0;
      hdrLen <= 8'h00;
      coded <= 1'b0;
    end else if (ctrlWr) begin
      wrCnt <= 2'h0;
      coded <= hostWr.data[0];
    end else if (hostWr.write && hostWr.addr == `RFM_ADDR_CMD_DATA && wrCnt != 2'h3) begin
      wrCnt <= wrCnt + 2'h1;
      if (wrCnt == 2'h2) hdrLen <= hostWr.data;
    end
  end
  tx_hold_a: assert property (
    txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast))
    else $error("tx byte dropped while stalled");
  tx_start_a: assert property (
    ctrlWr |=> txValid && txByte == `RFM_PREAMBLE) else $error("frame did not start");
  preamble_a: assert property (
    txValid && txPos < 14'h4 |-> txByte == `RFM_PREAMBLE) else $error("bad preamble");
  sync_word_a: assert property (
    txValid && txPos[13:1] == 13'h2 |-> txByte == (txPos[0] ? SYNC[7:0] : SYNC[15:8]))
    else $error("bad sync byte");
  hdr_len_a: assert property (
    txValid && !coded && txPos == 14'h9 |-> txByte == hdrLen + 8'h01)
    else $error("header length not raised");
  rx_head_a: assert property (
    rxValid && rxSyncFound |-> ##[1:4] rxOut.valid && rxOut.ctrl && rxOut.data[7])
    else $error("no frame control byte");
  rx_type_a: assert property (
    rxOut.valid && rxOut.ctrl && rxOut.data[7] |=> rxType == $past(rxOut.data[0]))
    else $error("frame type not reported");
  blk_ctrl_a: assert property (
    rxOut.valid && rxOut.ctrl && !rxOut.data[7] |-> rxOut.data[6:2] == 5'h0
      && rxOut.data[0] == rxType) else $error("bad block control byte");
  cover property (txValid && txReady && txLast);
  cover property (rxOut.valid && rxOut.ctrl && rxOut.data[1]);
  cover property (ctrlWr && hostWr.data[0]);
endmodule
bind rtcm_frame_formatter rfm_frame_chk #(.BLOCK_LEN(BLOCK_LEN), .MAX_FRAME(MAX_FRAME))
  rfm_frame_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hostWr(hostWr), .txValid(txValid),
  .txByte(txByte), .txLast(txLast), .txReady(txReady), .txBusy(txBusy), .rxValid(rxValid),
  .rxByte(rxByte), .rxSyncFound(rxSyncFound), .rxOut(rxOut), .rxType(rxType));

/* test/rfm_mod_model.sv */
// modulator model taking transmit bytes promptly or with stalls
`timescale 1ns/1ns
module rfm_mod_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // byte stream
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic txLast,
  output logic txReady,
  // pacing
  input wire logic slow
);
  logic [2:0] pace;
  // slow mode takes one byte in five, so the framer must hold its byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace <= 3'h0;
      txReady <= 1'b0;
    end else begin
      pace <= (pace == 3'h4) ? 3'h0 : pace + 3'h1;
      txReady <= !slow || pace == 3'h4;
    end
  end
endmodule

/* test/rtcm_frame_formatter_bench.sv */
// self-checking bench for the frame formatter
`timescale 1ns/1ns
`include "rfm_params.svh"
module rtcm_frame_formatter_bench import rfm_pkg::*; ;
  localparam int BLK = `RFM_BLOCK_LEN;
  localparam logic [15:0] SYNC = `RFM_SYNC_WORD;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow;
  rfm_hostwr_t hostWr = '0;
  logic rxValid = 1'b0;
  logic [7:0] rxByte;
  logic rxSyncFound;
  logic txValid;
  logic [7:0] txByte;
  logic txLast;
  logic txReady;
  logic txBusy;
  rfm_rxbyte_t rxOut;
  rfm_ftype_t rxType;
  logic [31:0] seed = 32'h49f0f3bf;
  logic [9:0] txExp[$];
  logic [8:0] rxExp[$];
  logic [7:0] seqLog[$];
  logic [9:0] e;
  logic [8:0] r;
  int txCnt = 0;
  int err_count = 0;
  int compares = 0;
  rtcm_frame_formatter rtcm_frame_formatter_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hostWr(hostWr),
    .txValid(txValid), .txByte(txByte), .txLast(txLast), .txReady(txReady),
    .rxValid(rxValid), .rxByte(rxByte), .rxSyncFound(rxSyncFound), .rxOut(rxOut),
    .rxType(rxType), .txBusy(txBusy));
  rfm_mod_model rfm_mod_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .txValid(txValid),
    .txByte(txByte), .txLast(txLast), .txReady(txReady), .slow(slow));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) x = x[15] ? (x << 1) ^ `RFM_CRC16_POLY : x << 1;
    return x;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hostWrite(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    hostWr <= '{write: 1'b1, addr: addr, data: data};
    @(posedge ref_clk);
    hostWr.write <= 1'b0;
  endtask
  // no fifo in front of the framer: wait until the byte has gone out
  task automatic dataByte(input logic [7:0] data, input int pos);
    int n;
    n = 0;
    hostWrite(`RFM_ADDR_CMD_DATA, data);
    while (txCnt <= pos && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic txFrame(input logic coded);
    logic [7:0] fr[5 + 2 * BLK];
    logic [15:0] crc;
    int n;
    txCnt = 0;
    for (int i = 0; i < 5 + 2 * BLK; i++) fr[i] = (i == 2) ? 8'h05 : rnd();
    repeat (4) txExp.push_back({2'b10, `RFM_PREAMBLE});
    txExp.push_back({2'b10, SYNC[15:8]});
    txExp.push_back({2'b10, SYNC[7:0]});
    txExp.push_back({2'b10, 7'h00, coded});
    for (int i = 0; i < 5; i++) begin
      txExp.push_back({i != 1, 1'b0, (i == 2) ? 8'h06 : fr[i]});
      if (coded) begin
        txExp.push_back(10'h0);
        txExp.push_back(10'h0);
      end
    end
    if (!coded) begin
      txExp.push_back(10'h0);
      crc = CRC_INIT;
      for (int j = 0; j < 2 * BLK; j++) begin
        txExp.push_back({2'b10, fr[j + 5]});
        crc = crc16(crc, fr[j + 5]);
        if (j % BLK == BLK - 1) begin
          txExp.push_back({2'b10, crc[15:8]});
          txExp.push_back({1'b1, j == 2 * BLK - 1, crc[7:0]});
          crc = CRC_INIT;
        end
      end
    end
    hostWrite(`RFM_ADDR_CMD_CTRL, coded ? 8'h01 : 8'h02);
    for (int i = 0; i < 5; i++) begin
      dataByte(fr[i], coded ? 9 + 3 * i : 7 + i);
      if (i == 2) hostWrite(`RFM_ADDR_CMD_CTRL, 8'h01);
    end
    if (!coded) begin
      for (int j = 0; j < 2 * BLK; j++) dataByte(fr[j + 5], 13 + j + 2 * (j / BLK));
      n = 0;
      while (txBusy && n < 400) begin
        @(posedge ref_clk);
        n++;
      end
      @(posedge ref_clk);
      check(16'(txExp.size()), 16'h0);
    end
  endtask
  task automatic rxSend(input logic [7:0] data, input logic sync);
    logic [7:0] g;
    g = rnd();
    @(posedge ref_clk);
    rxValid <= 1'b1;
    rxByte <= data;
    rxSyncFound <= sync;
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxSyncFound <= 1'b0;
    rxByte <= ~data;
    repeat (3 + g[1:0]) @(posedge ref_clk);
  endtask
  task automatic rxFrame();
    logic [7:0] d;
    logic [15:0] crc;
    rxExp.push_back(9'h180);
    rxSend(8'h00, 1'b1);
    for (int k = 0; k < 5; k++) begin
      d = (k == 3) ? 8'h02 : rnd();
      rxExp.push_back({1'b0, d});
      rxSend(d, 1'b0);
    end
    for (int b = 0; b < 2; b++) begin
      rxExp.push_back({1'b1, 6'h0, b[0], 1'b0});
      rxExp.push_back({1'b0, 4'(1 - b), 4'(b)});
      rxExp.push_back(9'h000);
      rxExp.push_back({1'b0, 8'(BLK)});
      crc = CRC_INIT;
      for (int j = 0; j < BLK; j++) begin
        d = rnd();
        rxExp.push_back({1'b0, d});
        crc = crc16(crc, d);
        rxSend(d, 1'b0);
      end
      // second block carries a damaged crc
      if (b == 1) crc = crc ^ 16'h0001;
      rxSend(crc[15:8], 1'b0);
      rxSend(crc[7:0], 1'b0);
      // bytes arriving while a block record is written out would be lost
      repeat (80) @(posedge ref_clk);
    end
  endtask
  always @(posedge ref_clk) begin
    if (rst_n && txValid && txReady) begin
      if (txCnt == 8) seqLog.push_back(txByte);
      txCnt++;
      if (txExp.size() > 0) begin
        e = txExp.pop_front();
        check({7'h0, txLast, e[9] ? txByte : 8'h00}, {7'h0, e[8], e[9] ? e[7:0] : 8'h00});
      end
    end
    if (rst_n && rxOut.valid && rxExp.size() > 0) begin
      r = rxExp.pop_front();
      check({7'h0, rxOut.ctrl, rxOut.data}, {7'h0, r});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    slow <= 1'b0;
    rxByte <= 8'h00;
    rxSyncFound <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    txFrame(1'b0);
    @(posedge ref_clk);
    slow <= 1'b1;
    txFrame(1'b0);
    check(16'(seqLog.size() == 2 && seqLog[0] != seqLog[1]), 16'h1);
    rxFrame();
    repeat (20) @(posedge ref_clk);
    check(16'(rxExp.size()), 16'h0);
    check({15'h0, rxType}, 16'h0);
    txFrame(1'b1);
    rxExp.push_back(9'h181);
    rxSend(8'h01, 1'b1);
    repeat (10) @(posedge ref_clk);
    check({15'h0, rxType}, 16'h1);
    // abort the coded frame mid-way with a second reset
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({14'h0, txBusy, rxOut.valid}, 16'h0);
    txExp.delete();
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule
